/* hw/psa_unit.sv */
// Packed SIMD add/subtract unit with its eight 64-bit register file
//
// Functional notes
// - Wrap mode drops carries, keeps low bits
// - Byte overflow clamps to 7F or FF
// - Byte underflow clamps to 80 or 00
// - Word saturation limits 8000-7FFF or 0000-FFFF
// - No exception or flag on overflow
// - Opcode picks byte, word or dword lanes
// - Two operands: destination first, source second
// - Destination is input and gets result
// - Source memory or register; destination register
// - Empty-state op has no operands
// - Dword move: register with memory or integer
// - Qword move: memory or register pairs
// - Wrap ops for byte, word, dword
// - Signed saturation, byte and word only
// - Unsigned saturation, byte and word only
// - Lane 0 holds the lowest bits
// - Eight 64-bit packed registers
`timescale 1ns/10ps
`include "psa_map.svh"
module psa_unit (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Operation issue from decode
   input wire logic OP_VALID,
   input wire psa_pkg::psa_op_t OP_CODE,
   input wire logic [2:0] OP_DST,
   input wire logic [2:0] OP_SRC,
   input wire psa_pkg::psa_kind_t OP_KIND,
   // Operand data from memory and integer registers
   input wire logic [63:0] MEM_RDATA,
   input wire logic [31:0] INT_RDATA,
   // Register writeback report
   output logic RESULT_VALID,
   output logic [2:0] RESULT_DST,
   output logic [63:0] RESULT,
   // Store path to memory
   output logic MEM_WRITE,
   output logic MEM_WIDE,
   output logic [63:0] MEM_WDATA,
   // Store path to integer registers
   output logic INT_WRITE,
   output logic [31:0] INT_WDATA,
   // Empty-state indication
   output logic STATE_EMPTIED,
   output logic STATE_EMPTY,
   // Register file observation
   input wire logic [2:0] DBG_SEL,
   output logic [63:0] DBG_DATA
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Maps an opcode onto adder controls; non-arith ops give is_arith low
   function automatic psa_pkg::psa_ctl_t decode(input psa_pkg::psa_op_t op);
      psa_pkg::psa_ctl_t c;
      c.is_arith = 1'b1;
      c.sub = op[3];            // Subtract group sits in the upper half
      c.size = psa_pkg::SZ_BYTE;
      c.sat = psa_pkg::SAT_WRAP;
      case (op)
         psa_pkg::add_bytes_wrap, psa_pkg::sub_bytes_wrap: begin
            c.size = psa_pkg::SZ_BYTE;
         end
         psa_pkg::add_words_wrap, psa_pkg::sub_words_wrap: begin
            c.size = psa_pkg::SZ_WORD;
         end
         psa_pkg::add_dwords_wrap, psa_pkg::sub_dwords_wrap: begin
            c.size = psa_pkg::SZ_DWORD;
         end
         psa_pkg::add_bytes_signed_sat, psa_pkg::sub_bytes_signed_sat: begin
            c.sat = psa_pkg::SAT_SIGNED;
         end
         psa_pkg::add_words_signed_sat, psa_pkg::sub_words_signed_sat: begin
            c.size = psa_pkg::SZ_WORD;
            c.sat = psa_pkg::SAT_SIGNED;
         end
         psa_pkg::add_bytes_unsigned_sat, psa_pkg::sub_bytes_unsigned_sat: begin
            c.sat = psa_pkg::SAT_UNSIGNED;
         end
         psa_pkg::add_words_unsigned_sat, psa_pkg::sub_words_unsigned_sat: begin
            c.size = psa_pkg::SZ_WORD;
            c.sat = psa_pkg::SAT_UNSIGNED;
         end
         default: begin
            // Moves, empty-state and unused codes
            c.is_arith = 1'b0;
            c.sub = 1'b0;
         end
      endcase
      return c;
   endfunction

   // ----------------------------------------
   // Storage and internal signals
   // ----------------------------------------
   logic [63:0] mm_reg [`PSA_NUM_REGS];   // Packed register file
   psa_pkg::psa_ctl_t ctl;                // Decoded controls
   logic [63:0] src_val;                  // Selected source operand
   logic next_wb_en;                      // Register write this cycle
   logic [63:0] next_wb_val;              // Value to write
   logic next_mem_wr;                     // Memory store this cycle
   logic next_mem_wide;                   // Store width 64 when high
   logic [63:0] next_mem_data;            // Store data
   logic next_int_wr;                     // Integer register store
   logic next_empty_op;                   // Empty-state op taken
   logic next_other_op;                   // Any other op taken

   psa_alu_if alu_bus ();                 // Adder operands and result

   // ----------------------------------------
   // Operand selection
   // ----------------------------------------
   assign ctl = decode(OP_CODE);

   // Source from memory or a packed register
   always_comb begin
      if (OP_KIND == psa_pkg::KIND_MEM) begin
         src_val = MEM_RDATA;
      end else begin
         src_val = mm_reg[OP_SRC];
      end
   end

   // Destination's prior value is the first input
   assign alu_bus.dst_val = mm_reg[OP_DST];
   assign alu_bus.src_val = src_val;
   assign alu_bus.sub = ctl.sub;
   assign alu_bus.size = ctl.size;
   assign alu_bus.sat = ctl.sat;

   // Lane adder, purely combinational so one op fits each clock
   psa_lane_alu u_alu (
      .alu(alu_bus.alu)
   );

   // ----------------------------------------
   // Operation steering
   // ----------------------------------------
   // Chooses what is written where; unsupported operand kinds are dropped
   always_comb begin
      next_wb_en = 1'b0;
      next_wb_val = `PSA_REG_RST;
      next_mem_wr = 1'b0;
      next_mem_wide = 1'b0;
      next_mem_data = `PSA_REG_RST;
      next_int_wr = 1'b0;
      next_empty_op = 1'b0;
      next_other_op = 1'b0;
      if (OP_VALID) begin
         if (ctl.is_arith) begin
            // Integer register cannot feed arithmetic
            if (OP_KIND != psa_pkg::KIND_INT) begin
               next_wb_en = 1'b1;
               next_wb_val = alu_bus.result;
               next_other_op = 1'b1;
            end
         end else begin
            case (OP_CODE)
               psa_pkg::doubleword_move_load: begin
                  // Low 32 bits in, upper half cleared
                  if (OP_KIND == psa_pkg::KIND_INT) begin
                     next_wb_en = 1'b1;
                     next_wb_val = {`PSA_HALF_ZERO, INT_RDATA};
                     next_other_op = 1'b1;
                  end else if (OP_KIND == psa_pkg::KIND_MEM) begin
                     next_wb_en = 1'b1;
                     next_wb_val = {`PSA_HALF_ZERO, MEM_RDATA[31:0]};
                     next_other_op = 1'b1;
                  end
               end
               psa_pkg::doubleword_move_store: begin
                  // Low half of a packed register goes out
                  next_mem_data = {`PSA_HALF_ZERO, mm_reg[OP_SRC][31:0]};
                  if (OP_KIND == psa_pkg::KIND_INT) begin
                     next_int_wr = 1'b1;
                     next_other_op = 1'b1;
                  end else if (OP_KIND == psa_pkg::KIND_MEM) begin
                     next_mem_wr = 1'b1;
                     next_other_op = 1'b1;
                  end
               end
               psa_pkg::quadword_move_load: begin
                  // From memory or another packed register
                  if (OP_KIND != psa_pkg::KIND_INT) begin
                     next_wb_en = 1'b1;
                     next_wb_val = src_val;
                     next_other_op = 1'b1;
                  end
               end
               psa_pkg::quadword_move_store: begin
                  // Whole 64 bits out to memory only
                  next_mem_data = mm_reg[OP_SRC];
                  if (OP_KIND == psa_pkg::KIND_MEM) begin
                     next_mem_wr = 1'b1;
                     next_mem_wide = 1'b1;
                     next_other_op = 1'b1;
                  end
               end
               psa_pkg::empty_state_op: begin
                  // Operand fields are ignored entirely
                  next_empty_op = 1'b1;
               end
               default: begin
                  // Unused code: no effect
                  next_wb_en = 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Register file update
   // ----------------------------------------
   // Written at the issue edge, so a following op reads the new value
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         for (int i = 0; i < `PSA_NUM_REGS; i++) begin
            mm_reg[i] <= `PSA_REG_RST;
         end
      end else if (next_wb_en) begin
         mm_reg[OP_DST] <= next_wb_val;   // Same register overwritten
      end
   end

   // ----------------------------------------
   // Writeback report
   // ----------------------------------------
   // One-cycle pulse on the edge after issue; no overflow status exists
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         RESULT_VALID <= 1'b0;
         RESULT_DST <= `PSA_SEL_RST;
         RESULT <= `PSA_REG_RST;
      end else begin
         RESULT_VALID <= next_wb_en;
         if (next_wb_en) begin
            RESULT_DST <= OP_DST;
            RESULT <= next_wb_val;
         end
      end
   end

   // ----------------------------------------
   // Store paths
   // ----------------------------------------
   // Data holds until the next store; strobes last one cycle
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         MEM_WRITE <= 1'b0;
         MEM_WIDE <= 1'b0;
         MEM_WDATA <= `PSA_REG_RST;
         INT_WRITE <= 1'b0;
         INT_WDATA <= `PSA_HALF_ZERO;
      end else begin
         MEM_WRITE <= next_mem_wr;
         INT_WRITE <= next_int_wr;
         if (next_mem_wr) begin
            MEM_WIDE <= next_mem_wide;
            MEM_WDATA <= next_mem_data;
         end
         if (next_int_wr) begin
            INT_WDATA <= next_mem_data[31:0];
         end
      end
   end

   // ----------------------------------------
   // Empty-state tracking
   // ----------------------------------------
   // Level goes high on the empty op and low on any other accepted op;
   // both cannot happen in one cycle since only one op issues
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         STATE_EMPTIED <= 1'b0;
         STATE_EMPTY <= `PSA_EMPTY_RST;
      end else begin
         STATE_EMPTIED <= next_empty_op;
         if (next_empty_op) begin
            STATE_EMPTY <= 1'b1;
         end else if (next_other_op) begin
            STATE_EMPTY <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Observation port
   // ----------------------------------------
   // Registered read, one cycle behind DBG_SEL
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         DBG_DATA <= `PSA_REG_RST;
      end else begin
         DBG_DATA <= mm_reg[DBG_SEL];
      end
   end

endmodule // psa_unit

/* hw/psa_map.svh */
// Constants for the packed SIMD add/subtract unit
`ifndef PSA_MAP_SVH
`define PSA_MAP_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define PSA_DATA_W 64
`define PSA_HALF_W 32
`define PSA_NUM_REGS 8
`define PSA_SEL_W 3
`define PSA_LANES 8

// ----------------------------------------
// Saturation byte patterns
// ----------------------------------------
`define PSA_SMAX_TOP 8'h7F
`define PSA_SMIN_TOP 8'h80
`define PSA_ONES 8'hFF
`define PSA_ZEROS 8'h00

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSA_REG_RST 64'h0000_0000_0000_0000
`define PSA_HALF_ZERO 32'h0000_0000
`define PSA_SEL_RST 3'h0
`define PSA_EMPTY_RST 1'h1

`endif

/* hw/psa_pkg.sv */
// Types for the packed SIMD add/subtract unit
package psa_pkg;

   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      add_bytes_wrap = 5'h00,
      add_words_wrap = 5'h01,
      add_dwords_wrap = 5'h02,
      add_bytes_signed_sat = 5'h03,
      add_words_signed_sat = 5'h04,
      add_bytes_unsigned_sat = 5'h05,
      add_words_unsigned_sat = 5'h06,
      sub_bytes_wrap = 5'h08,
      sub_words_wrap = 5'h09,
      sub_dwords_wrap = 5'h0A,
      sub_bytes_signed_sat = 5'h0B,
      sub_words_signed_sat = 5'h0C,
      sub_bytes_unsigned_sat = 5'h0D,
      sub_words_unsigned_sat = 5'h0E,
      doubleword_move_load = 5'h10,
      doubleword_move_store = 5'h11,
      quadword_move_load = 5'h12,
      quadword_move_store = 5'h13,
      empty_state_op = 5'h1F
   } psa_op_t;

   // Element size of a packed operation
   typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2} psa_size_t;

   // Overflow handling
   typedef enum logic [1:0] {SAT_WRAP = 2'h0, SAT_SIGNED = 2'h1, SAT_UNSIGNED = 2'h2} psa_sat_t;

   // Where the non-register operand lives
   typedef enum logic [1:0] {KIND_MMREG = 2'h0, KIND_MEM = 2'h1, KIND_INT = 2'h2} psa_kind_t;

   // Decoded arithmetic control
   typedef struct packed {
      logic is_arith;
      logic sub;
      psa_size_t size;
      psa_sat_t sat;
   } psa_ctl_t;

endpackage

/* hw/psa_alu_if.sv */
// Operand and result bundle between the unit and its lane adder
`timescale 1ns/10ps
interface psa_alu_if;
   logic [63:0] dst_val;       // Destination prior value
   logic [63:0] src_val;       // Source value
   logic sub;                  // Subtract when high
   psa_pkg::psa_size_t size;   // Element size
   psa_pkg::psa_sat_t sat;     // Overflow handling
   logic [63:0] result;        // Packed result

   // Side that supplies operands
   modport requester (output dst_val, output src_val, output sub, output size, output sat, input result);
   // Side that computes
   modport alu (input dst_val, input src_val, input sub, input size, input sat, output result);
endinterface

/* hw/psa_lane_alu.sv */
// Combinational lane-segmented adder with wrap and saturation
`timescale 1ns/10ps
`include "psa_map.svh"
module psa_lane_alu (
   // Operands and result
   psa_alu_if.alu alu
);

   // ----------------------------------------
   // Element geometry helpers
   // ----------------------------------------
   // Low index bits that lie inside one element
   function automatic logic [2:0] elem_mask(input psa_pkg::psa_size_t size);
      case (size)
         psa_pkg::SZ_WORD: return 3'h1;
         psa_pkg::SZ_DWORD: return 3'h3;
         default: return 3'h0;
      endcase
   endfunction

   // Index of the top byte of the element holding byte idx
   function automatic logic [2:0] elem_top(input logic [2:0] idx, input psa_pkg::psa_size_t size);
      return idx | elem_mask(size);
   endfunction

   logic [7:0] raw [8];    // Wrapped byte sums
   logic cout [8];         // Carry out of each byte
   logic [7:0] opb [8];    // Source byte, inverted for subtract

   // ----------------------------------------
   // Byte adders, chained only inside an element
   // ----------------------------------------
   always_comb begin
      logic [8:0] sum;
      logic cin;
      sum = 9'h000;
      cin = 1'b0;
      for (int i = 0; i < `PSA_LANES; i++) begin
         opb[i] = alu.src_val[i*8 +: 8] ^ {8{alu.sub}};
         // Element boundary breaks the chain
         if ((3'(i) & elem_mask(alu.size)) == 3'h0) begin
            cin = alu.sub;
         end else begin
            cin = cout[i-1];
         end
         sum = {1'b0, alu.dst_val[i*8 +: 8]} + {1'b0, opb[i]} + {8'h00, cin};
         raw[i] = sum[7:0];     // Carry beyond element dropped
         cout[i] = sum[8];
      end
   end

   // ----------------------------------------
   // Clamp per element, judged at its top byte
   // ----------------------------------------
   always_comb begin
      logic [2:0] t;
      logic a_s;
      logic b_s;
      logic ovf_s;
      logic ovf_u;
      t = 3'h0;
      a_s = 1'b0;
      b_s = 1'b0;
      ovf_s = 1'b0;
      ovf_u = 1'b0;
      alu.result = `PSA_REG_RST;
      for (int i = 0; i < `PSA_LANES; i++) begin
         t = elem_top(3'(i), alu.size);
         a_s = alu.dst_val[{t, 3'h7}];
         b_s = opb[t][7];
         ovf_s = (a_s == b_s) && (raw[t][7] != a_s);
         // Unsigned add overflows on carry, subtract on missing carry
         ovf_u = alu.sub ? !cout[t] : cout[t];
         if (alu.sat == psa_pkg::SAT_SIGNED && ovf_s) begin
            // Sign of dst tells the direction
            if (a_s) begin
               alu.result[i*8 +: 8] = (3'(i) == t) ? `PSA_SMIN_TOP : `PSA_ZEROS;
            end else begin
               alu.result[i*8 +: 8] = (3'(i) == t) ? `PSA_SMAX_TOP : `PSA_ONES;
            end
         end else if (alu.sat == psa_pkg::SAT_UNSIGNED && ovf_u) begin
            alu.result[i*8 +: 8] = alu.sub ? `PSA_ZEROS : `PSA_ONES;
         end else begin
            alu.result[i*8 +: 8] = raw[i];
         end
      end
   end

endmodule // psa_lane_alu

/* tb/psa_far_model.sv */
// Far-side model: memory and integer operands
`timescale 1ns/10ps
module psa_far_model (
   // Clock and reset
   input logic mclk,
   input logic reset,
   // Bench override for corner cases
   input logic preset_en,
   input logic [63:0] preset_data,
   // Read data toward the unit
   output logic [63:0] mem_rdata,
   output logic [31:0] int_rdata
);
   // --------
   // Read pattern
   // --------
   logic [63:0] pat; // Free-running, so stale reads differ

   // Shift the pattern every cycle
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pat <= 64'h1357_9bdf_2468_ace1;
      end else begin
         pat <= {pat[62:0], pat[63] ^ pat[62] ^ pat[60] ^ pat[59]};
      end
   end

   // Memory operand
   assign mem_rdata = preset_en ? preset_data : pat;
   // Integer operand
   assign int_rdata = ~mem_rdata[47:16];
endmodule // psa_far_model

/* tb/psa_unit_asserts.sv */
// Port checks for the packed add/subtract unit
`timescale 1ns/10ps
module psa_unit_asserts (
   // Clock and reset
   input logic MCLK,
   input logic RESET,
   // Issue and operand data
   input logic OP_VALID,
   input psa_pkg::psa_op_t OP_CODE,
   input logic [2:0] OP_DST,
   input psa_pkg::psa_kind_t OP_KIND,
   input logic [63:0] MEM_RDATA,
   input logic [31:0] INT_RDATA,
   // Results and stores
   input logic RESULT_VALID,
   input logic [2:0] RESULT_DST,
   input logic [63:0] RESULT,
   input logic MEM_WRITE,
   input logic MEM_WIDE,
   input logic INT_WRITE,
   // State and observation
   input logic STATE_EMPTIED,
   input logic STATE_EMPTY,
   input logic [2:0] DBG_SEL,
   input logic [63:0] DBG_DATA
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   // --------
   // Decode helpers
   // --------
   logic arith; // Used arithmetic opcode
   logic take; // Accepted arithmetic op
   assign arith = OP_CODE < 5'h10 && OP_CODE[2:0] != 3'h7;
   assign take = OP_VALID && arith && OP_KIND != psa_pkg::KIND_INT;

   // --------
   // Properties
   // --------
   AST_ARITH_LAT: assert property (take |=> RESULT_VALID && RESULT_DST == $past(OP_DST))
      else $error("arith write missing");
   AST_INT_REFUSED: assert property (OP_VALID && arith && OP_KIND == psa_pkg::KIND_INT |=> !RESULT_VALID)
      else $error("integer source taken");
   AST_NO_CAUSE: assert property (RESULT_VALID |-> $past(OP_VALID))
      else $error("write without issue");
   AST_EMPTY_OP: assert property (OP_VALID && OP_CODE == psa_pkg::empty_state_op
      |=> STATE_EMPTIED && STATE_EMPTY && !RESULT_VALID)
      else $error("empty op wrong");
   AST_EMPTY_CLR: assert property (take |=> !STATE_EMPTY && !STATE_EMPTIED)
      else $error("empty not cleared");
   AST_QSTORE: assert property (OP_VALID && OP_CODE == psa_pkg::quadword_move_store && OP_KIND == psa_pkg::KIND_MEM
      |=> MEM_WRITE && MEM_WIDE && !INT_WRITE && !RESULT_VALID)
      else $error("wide store wrong");
   AST_QLOAD: assert property (OP_VALID && OP_CODE == psa_pkg::quadword_move_load && OP_KIND == psa_pkg::KIND_MEM
      |=> RESULT_VALID && RESULT == $past(MEM_RDATA))
      else $error("wide load wrong");
   AST_DLOAD: assert property (OP_VALID && OP_CODE == psa_pkg::doubleword_move_load && OP_KIND == psa_pkg::KIND_INT
      |=> RESULT == 64'($past(INT_RDATA)))
      else $error("narrow load wrong");
   AST_DSTORE: assert property (OP_VALID && OP_CODE == psa_pkg::doubleword_move_store && OP_KIND == psa_pkg::KIND_INT
      |=> INT_WRITE && !MEM_WRITE)
      else $error("integer store wrong");
   AST_DBG_WB: assert property (RESULT_VALID && DBG_SEL == RESULT_DST |=> DBG_DATA == $past(RESULT))
      else $error("register not written");

   // Main scenarios
   COV_B2B: cover property (take ##1 take);
   COV_EMPTY: cover property (STATE_EMPTIED);
   COV_NARROW: cover property (MEM_WRITE && !MEM_WIDE);
endmodule // psa_unit_asserts

bind psa_unit psa_unit_asserts u_chk (
   .MCLK, .RESET, .OP_VALID, .OP_CODE, .OP_DST, .OP_KIND, .MEM_RDATA, .INT_RDATA, .RESULT_VALID, .RESULT_DST,
   .RESULT, .MEM_WRITE, .MEM_WIDE, .INT_WRITE, .STATE_EMPTIED, .STATE_EMPTY, .DBG_SEL, .DBG_DATA);

/* tb/psa_unit_tb.sv */
// Self-checking bench for the packed add/subtract unit
`timescale 1ns/10ps
module psa_unit_tb;
   // --------
   // Signals
   // --------
   logic mclk, reset, op_valid, preset_en; // Clock, reset and strobes
   psa_pkg::psa_op_t op_code; // Opcode under issue
   psa_pkg::psa_kind_t op_kind; // Operand location
   logic [2:0] op_dst, op_src, dbg_sel, result_dst; // Register indices
   logic [63:0] mem_rdata, preset_data, result, mem_wdata, dbg_data; // Wide data
   logic [31:0] int_rdata, int_wdata; // Narrow data
   logic result_valid, mem_write, mem_wide, int_write, state_emptied, state_empty; // Status
   logic [63:0] ref_reg [8]; // Expected register file
   logic exp_empty; // Expected empty level
   int n_mismatch, check_count; // Counters

   psa_unit uut (.MCLK(mclk), .RESET(reset), .OP_VALID(op_valid), .OP_CODE(op_code), .OP_DST(op_dst),
      .OP_SRC(op_src), .OP_KIND(op_kind), .MEM_RDATA(mem_rdata), .INT_RDATA(int_rdata),
      .RESULT_VALID(result_valid), .RESULT_DST(result_dst), .RESULT(result), .MEM_WRITE(mem_write),
      .MEM_WIDE(mem_wide), .MEM_WDATA(mem_wdata), .INT_WRITE(int_write), .INT_WDATA(int_wdata),
      .STATE_EMPTIED(state_emptied), .STATE_EMPTY(state_empty), .DBG_SEL(dbg_sel), .DBG_DATA(dbg_data));
   psa_far_model u_far (.mclk(mclk), .reset(reset), .preset_en(preset_en), .preset_data(preset_data),
      .mem_rdata(mem_rdata), .int_rdata(int_rdata));

   // 25 MHz clock
   always #20 mclk = ~mclk;

   // --------
   // Helpers
   // --------
   task automatic check(input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Ideal lane arithmetic in wide integers
   function automatic logic [63:0] calc(input psa_pkg::psa_op_t op, input logic [63:0] d, input logic [63:0] s);
      int w, sat;
      longint m, a, b, r;
      logic [63:0] res;
      w = (op[2:0] == 3'h2) ? 32 : (op[2:0] inside {3'h1, 3'h4, 3'h6}) ? 16 : 8;
      sat = (op[2:0] < 3'h3) ? 0 : (op[2:0] < 3'h5) ? 1 : 2;
      m = (longint'(1) << w) - 1;
      res = '0;
      for (int i = 0; i < 64 / w; i++) begin
         a = longint'(d >> (i * w)) & m;
         b = longint'(s >> (i * w)) & m;
         // Signed lanes in two's complement
         if (sat == 1 && a[w-1]) a -= m + 1;
         if (sat == 1 && b[w-1]) b -= m + 1;
         r = op[3] ? a - b : a + b;
         if (sat == 1) r = (r > m / 2) ? m / 2 : (r < -(m / 2) - 1) ? -(m / 2) - 1 : r;
         if (sat == 2) r = (r > m) ? m : (r < 0) ? 0 : r;
         // Keep each lane's low bits
         res |= (64'(r) & 64'(m)) << (i * w);
      end
      return res;
   endfunction

   // One issue, then every output checked in the answer cycle
   task automatic run(input psa_pkg::psa_op_t op, input logic [2:0] dst, input logic [2:0] src,
      input psa_pkg::psa_kind_t kind);
      logic [63:0] sv, e;
      int what; // 0 write, 1 memory store, 2 integer store, 3 nothing
      @(posedge mclk);
      op_valid <= 1'h1;
      op_code <= op;
      op_dst <= dst;
      op_src <= src;
      op_kind <= kind;
      dbg_sel <= 3'($urandom);
      #1;
      sv = (kind == psa_pkg::KIND_MEM) ? mem_rdata : (kind == psa_pkg::KIND_INT) ? 64'(int_rdata) : ref_reg[src];
      what = 3;
      e = sv;
      case (op)
         psa_pkg::doubleword_move_load: if (kind != psa_pkg::KIND_MMREG) begin
            what = 0;
            e = 64'(sv[31:0]);
         end
         psa_pkg::quadword_move_load: if (kind != psa_pkg::KIND_INT) what = 0;
         psa_pkg::doubleword_move_store: if (kind != psa_pkg::KIND_MMREG) begin
            what = (kind == psa_pkg::KIND_MEM) ? 1 : 2;
            e = 64'(ref_reg[src][31:0]);
         end
         psa_pkg::quadword_move_store: if (kind == psa_pkg::KIND_MEM) begin
            what = 1;
            e = ref_reg[src];
         end
         psa_pkg::empty_state_op: what = 3;
         default: if (kind != psa_pkg::KIND_INT && op[2:0] != 3'h7) begin
            what = 0;
            e = calc(op, ref_reg[dst], sv);
         end
      endcase
      @(posedge mclk);
      op_valid <= 1'h0;
      #1;
      check(64'(result_valid), 64'(what == 0));
      check(64'(mem_write), 64'(what == 1));
      check(64'(int_write), 64'(what == 2));
      check(64'(state_emptied), 64'(op == psa_pkg::empty_state_op));
      check(dbg_data, ref_reg[dbg_sel]);
      if (what == 0) begin
         check(result, e);
         check(64'(result_dst), 64'(dst));
         ref_reg[dst] = e;
      end
      if (what == 1) check(mem_wdata, e);
      if (what == 1) check(64'(mem_wide), 64'(op == psa_pkg::quadword_move_store));
      if (what == 2) check(64'(int_wdata), e);
      if (op == psa_pkg::empty_state_op) exp_empty = 1'h1;
      else if (what != 3) exp_empty = 1'h0;
      check(64'(state_empty), 64'(exp_empty));
   endtask

   // Read the file back through stores
   task automatic dump();
      for (int r = 0; r < 8; r++) run(psa_pkg::quadword_move_store, 3'h0, 3'(r), psa_pkg::KIND_MEM);
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      stop_test();
   end

   // --------
   // Main sequence
   // --------
   initial begin
      logic [63:0] pa [6];
      int c;
      pa = '{64'h7f80_00ff_7fff_8000, 64'h0101_0101_0001_0001, 64'h8000_0000_ff80_0102,
         64'hffff_0001_0102_0203, 64'hffff_ffff_8000_0000, 64'h0000_0001_8000_0000};
      {mclk, reset, op_valid, preset_en, op_dst, op_src, dbg_sel} = {4'h4, 9'h000};
      op_code = psa_pkg::empty_state_op;
      op_kind = psa_pkg::KIND_MMREG;
      preset_data = '0;
      n_mismatch = 0;
      check_count = 0;
      exp_empty = 1'h1;
      foreach (ref_reg[i]) ref_reg[i] = '0;
      void'($urandom(32'ha62b_bac9));
      repeat (3) @(posedge mclk);
      reset <= 1'h0;
      #1;
      check(64'(state_empty), 64'h1);
      check(result, 64'h0);
      // Corner operands through every arithmetic code, odd codes from memory, even codes from a register
      for (int p = 0; p < 3; p++) begin
         @(posedge mclk);
         preset_en <= 1'h1;
         preset_data <= pa[2 * p];
         run(psa_pkg::quadword_move_load, 3'h0, 3'h0, psa_pkg::KIND_MEM);
         preset_data <= pa[2 * p + 1];
         run(psa_pkg::quadword_move_load, 3'h1, 3'h0, psa_pkg::KIND_MEM);
         for (int k = 0; k < 15; k++) begin
            if (k == 7) continue;
            run(psa_pkg::quadword_move_load, 3'h2, 3'h0, psa_pkg::KIND_MMREG);
            run(psa_pkg::psa_op_t'(5'(k)), 3'h2, 3'h1, k[0] ? psa_pkg::KIND_MEM : psa_pkg::KIND_MMREG);
         end
      end
      preset_en <= 1'h0;
      // Random codes and kinds, refusals and an unused code among them
      repeat (200) begin
         c = $urandom_range(0, 20);
         c = (c < 7) ? c : (c < 14) ? c + 1 : (c < 18) ? c + 2 : (c < 20) ? 31 : 15;
         run(psa_pkg::psa_op_t'(5'(c)), 3'($urandom), 3'($urandom), psa_pkg::psa_kind_t'($urandom_range(0, 2)));
      end
      dump();
      // Reset in mid-run clears the whole file
      @(posedge mclk);
      reset <= 1'h1;
      repeat (2) @(posedge mclk);
      reset <= 1'h0;
      foreach (ref_reg[i]) ref_reg[i] = '0;
      exp_empty = 1'h1;
      dump();
      stop_test();
   end
endmodule // psa_unit_tb
